/* verilog/watchdog_power.sv */
// module: watchdog counter, reset generator and power-mode controller
// Contract
// - 8-bit watchdog overflow resets whole microcontroller
// - counter increments once per 2 ms tick
// - interval equals 256 minus reload, times tick
// - reload write loads only when load-enable set
// - load-enable clears when counter loads
// - enable runs watchdog and blocks power-down
// - watchdog and reset keep running in idle
// - standby bit disables analog, rest keeps running
// - idle gates clock from cpu only
// - idle preserves cpu state and pin levels
// - enabled interrupt clears idle, restarts cpu
// - two general flags writable with idle bit
// - reset held two machine cycles ends idle
// - power-down bit stops oscillator when watchdog off
// - power-down retains registers and pin latches
// - wake waits 2048 oscillator cycles before clock
// - level external interrupt wakes from power-down
`timescale 1ns/100ps
`default_nettype none
module watchdog_power (
   input  wire logic              clk,            // system clock, 100 MHz
   input  wire logic              sys_rst,        // synchronous reset, active high
   input  wire wdpm_pkg::sfr_req_t sfr_req,       // register bus request
   output logic [7:0]             sfr_rdata,      // registered read data
   input  wire logic              ext_reset_pin,  // external reset pin, high active
   input  wire logic              irq_pending,    // any enabled interrupt, same clock
   input  wire logic              ext_irq_level,  // enabled level external interrupt, pin
   output logic                   cpu_clk_en,     // cpu clock enable
   output logic                   periph_clk_en,  // timers, serial, interrupt clock enable
   output logic                   osc_run,        // oscillator running
   output logic                   analog_en,      // analog functions enabled
   output logic                   pin_hold,       // port pins hold latched levels
   output logic                   chip_reset      // internal reset to whole device
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic       rst_pin_s1_q;  // first stage, reset pin
   logic       rst_pin_s2_q;  // second stage, reset pin
   logic       irq_pin_s1_q;  // first stage, level interrupt
   logic       irq_pin_s2_q;  // second stage, level interrupt
   // control and status
   logic [7:0] reload_q;      // watchdog counter
   logic       load_en_q;     // watchdog load enable
   logic       wd_en_q;       // watchdog enable
   logic       busy_q;        // busy interrupt enable, plain storage
   logic       gflag0_q;      // general flag 0
   logic       gflag1_q;      // general flag 1
   logic       halt_q;        // idle select
   logic       pdown_q;       // power-down select
   logic       standby_q;     // standby select
   wdpm_pkg::pm_state_t pm_q; // power-mode state
   logic [11:0] wake_cnt_q;   // oscillator settle counter
   logic [23:0] tick_cnt_q;   // 2 ms divider
   logic        tick;         // one-cycle tick enable
   logic [4:0]  rst_hold_q;   // external reset hold counter
   logic [4:0]  rst_pulse_q;  // internal reset stretcher
   logic        ext_rst_ok;   // reset pin held long enough
   logic        int_rst;      // reset applied to registers
   logic        overflow;     // counter wraps this cycle
   logic        wr;           // qualified write

   // synchronise pins before any logic reads them
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rst_pin_s1_q <= 1'b0;
         rst_pin_s2_q <= 1'b0;
         irq_pin_s1_q <= 1'b0;
         irq_pin_s2_q <= 1'b0;
      end else begin
         rst_pin_s1_q <= ext_reset_pin;
         rst_pin_s2_q <= rst_pin_s1_q;
         irq_pin_s1_q <= ext_irq_level;
         irq_pin_s2_q <= irq_pin_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // reset generation
   // ----------------------------------------------------------------
   // count how long the reset pin stays high; runs even in power-down
   always_ff @(posedge clk) begin
      if (sys_rst || !rst_pin_s2_q) begin
         rst_hold_q <= 5'h00;
      end else if (!ext_rst_ok) begin
         rst_hold_q <= rst_hold_q + 5'h01;
      end
   end
   assign ext_rst_ok = (rst_hold_q == 5'(wdpm_pkg::RESET_HOLD_CYC));

   // stretch any reset cause to at least two machine cycles
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rst_pulse_q <= 5'(wdpm_pkg::RESET_PULSE_CYC);
      end else if (overflow || ext_rst_ok) begin
         rst_pulse_q <= 5'(wdpm_pkg::RESET_PULSE_CYC);
      end else if (rst_pulse_q != 5'h00) begin
         rst_pulse_q <= rst_pulse_q - 5'h01;
      end
   end
   assign int_rst = sys_rst || (rst_pulse_q != 5'h00);

   // device reset output, registered
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         chip_reset <= 1'b1;
      end else begin
         chip_reset <= (rst_pulse_q != 5'h00) || overflow;
      end
   end

   // ----------------------------------------------------------------
   // watchdog tick and counter
   // ----------------------------------------------------------------
   // tick divider; keeps counting in idle, stops with the oscillator
   always_ff @(posedge clk) begin
      if (int_rst || !wd_en_q || pm_q == wdpm_pkg::PM_DOWN) begin
         tick_cnt_q <= 24'h000000;
      end else if (tick) begin
         tick_cnt_q <= 24'h000000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 24'h000001;
      end
   end
   assign tick = (tick_cnt_q == 24'(wdpm_pkg::TICK_CYCLES - 1));

   assign wr       = sfr_req.we && (pm_q == wdpm_pkg::PM_RUN) && !halt_q;
   assign overflow = tick && (reload_q == 8'hFF);

   // counter: reload on enabled write, else count ticks
   always_ff @(posedge clk) begin
      if (int_rst) begin
         reload_q <= wdpm_pkg::WATCHDOG_RELOAD_RST;
      end else if (wr && sfr_req.addr == wdpm_pkg::WATCHDOG_RELOAD_ADDR && load_en_q) begin
         reload_q <= sfr_req.wdata;
      end else if (tick) begin
         reload_q <= reload_q + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   // power control: flags, load enable, mode selects
   always_ff @(posedge clk) begin
      if (int_rst) begin
         load_en_q <= 1'b0;
         gflag0_q  <= 1'b0;
         gflag1_q  <= 1'b0;
         halt_q    <= 1'b0;
         pdown_q   <= 1'b0;
      end else if (wr && sfr_req.addr == wdpm_pkg::POWER_CONTROL_ADDR) begin
         load_en_q <= sfr_req.wdata[wdpm_pkg::LOAD_ENABLE_BIT];
         gflag0_q  <= sfr_req.wdata[wdpm_pkg::GFLAG0_BIT];
         gflag1_q  <= sfr_req.wdata[wdpm_pkg::GFLAG1_BIT];
         halt_q    <= sfr_req.wdata[wdpm_pkg::CPU_HALT_BIT];
         pdown_q   <= sfr_req.wdata[wdpm_pkg::POWERDOWN_BIT] && !wd_en_q;
      end else begin
         if (wr && sfr_req.addr == wdpm_pkg::WATCHDOG_RELOAD_ADDR && load_en_q) begin
            load_en_q <= 1'b0;
         end
         if (halt_q && irq_pending) begin
            halt_q <= 1'b0;
         end
         if (pm_q == wdpm_pkg::PM_DOWN && irq_pin_s2_q) begin
            pdown_q <= 1'b0;
         end
      end
   end

   // standby and watchdog control
   always_ff @(posedge clk) begin
      if (int_rst) begin
         standby_q <= 1'b0;
         wd_en_q   <= wdpm_pkg::WD_ENABLE_RST;
         busy_q    <= 1'b0;
      end else if (wr && sfr_req.addr == wdpm_pkg::STANDBY_CONTROL_ADDR) begin
         standby_q <= sfr_req.wdata[wdpm_pkg::STANDBY_BIT];
      end else if (wr && sfr_req.addr == wdpm_pkg::BUSY_WATCHDOG_ADDR) begin
         wd_en_q <= sfr_req.wdata[wdpm_pkg::WD_ENABLE_BIT];
         busy_q  <= sfr_req.wdata[wdpm_pkg::BUSY_BIT];
      end
   end

   // registered read data; reserved bits read zero
   always_ff @(posedge clk) begin
      if (int_rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_req.re) begin
         case (sfr_req.addr)
            wdpm_pkg::POWER_CONTROL_ADDR:
               sfr_rdata <= {3'h0, load_en_q, gflag1_q, gflag0_q, pdown_q, halt_q};
            wdpm_pkg::STANDBY_CONTROL_ADDR:
               sfr_rdata <= {7'h00, standby_q};
            wdpm_pkg::BUSY_WATCHDOG_ADDR:
               sfr_rdata <= {6'h00, wd_en_q, busy_q};
            wdpm_pkg::WATCHDOG_RELOAD_ADDR:
               sfr_rdata <= reload_q;
            default:
               sfr_rdata <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // power-mode sequencer
   // ----------------------------------------------------------------
   // mode state; mode bits take effect the cycle after the write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pm_q <= wdpm_pkg::PM_RUN;
      end else begin
         case (pm_q)
            wdpm_pkg::PM_RUN: begin
               if (int_rst) begin
                  pm_q <= wdpm_pkg::PM_RUN;
               end else if (pdown_q) begin
                  pm_q <= wdpm_pkg::PM_DOWN;
               end else if (halt_q) begin
                  pm_q <= wdpm_pkg::PM_IDLE;
               end
            end
            wdpm_pkg::PM_IDLE: begin
               if (int_rst || !halt_q) begin
                  pm_q <= wdpm_pkg::PM_RUN;
               end
            end
            wdpm_pkg::PM_DOWN: begin
               if (ext_rst_ok || irq_pin_s2_q) begin
                  pm_q <= wdpm_pkg::PM_WAKE;
               end
            end
            wdpm_pkg::PM_WAKE: begin
               if (wake_cnt_q == 12'(wdpm_pkg::WAKE_OSC_CYCLES - 1)) begin
                  pm_q <= wdpm_pkg::PM_RUN;
               end
            end
            default: pm_q <= wdpm_pkg::PM_RUN;
         endcase
      end
   end

   // oscillator settle counter while waking
   always_ff @(posedge clk) begin
      if (sys_rst || pm_q != wdpm_pkg::PM_WAKE) begin
         wake_cnt_q <= 12'h000;
      end else begin
         wake_cnt_q <= wake_cnt_q + 12'h001;
      end
   end

   // clock gating and mode outputs, registered
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cpu_clk_en    <= 1'b1;
         periph_clk_en <= 1'b1;
         osc_run       <= 1'b1;
         analog_en     <= 1'b1;
         pin_hold      <= 1'b0;
      end else begin
         cpu_clk_en    <= (pm_q == wdpm_pkg::PM_RUN) && !halt_q && !pdown_q;
         periph_clk_en <= (pm_q == wdpm_pkg::PM_RUN) || (pm_q == wdpm_pkg::PM_IDLE);
         osc_run       <= (pm_q != wdpm_pkg::PM_DOWN);
         analog_en     <= !standby_q;
         pin_hold      <= (pm_q != wdpm_pkg::PM_RUN) || halt_q || pdown_q;
      end
   end
endmodule
`default_nettype wire

/* verilog/wdpm_pkg.sv */
// package: register map, field layout and timing constants for watchdog and power modes
package wdpm_pkg;
   // ----------------------------------------------------------------
   // register addresses on the special-function bus
   // ----------------------------------------------------------------
   localparam logic [7:0] POWER_CONTROL_ADDR   = 8'h87; // power control
   localparam logic [7:0] STANDBY_CONTROL_ADDR = 8'h92; // standby control
   localparam logic [7:0] BUSY_WATCHDOG_ADDR   = 8'hEB; // busy and watchdog control
   localparam logic [7:0] WATCHDOG_RELOAD_ADDR = 8'hFF; // watchdog reload value
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CPU_HALT_BIT    = 0; // idle select
   localparam int POWERDOWN_BIT   = 1; // power-down select
   localparam int GFLAG0_BIT      = 2; // general flag 0
   localparam int GFLAG1_BIT      = 3; // general flag 1
   localparam int LOAD_ENABLE_BIT = 4; // watchdog load enable
   localparam int STANDBY_BIT     = 0; // standby select
   localparam int BUSY_BIT        = 0; // busy interrupt enable bit
   localparam int WD_ENABLE_BIT   = 1; // watchdog enable
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] WATCHDOG_RELOAD_RST = 8'h00; // counter after reset
   localparam logic       WD_ENABLE_RST       = 1'b0;  // watchdog off after reset
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_HZ     = 100000000;            // system clock
   localparam int TICK_TIME_US    = 2000;                 // watchdog tick, 2 ms
   localparam int TICK_CYCLES     = TICK_TIME_US * (CLK_FREQ_HZ / 1000000);
   localparam int WAKE_OSC_CYCLES = 2048;                 // oscillator settle count
   localparam int RESET_PULSE_CYC = 24;                   // two machine cycles of 12 clocks
   localparam int RESET_HOLD_CYC  = 24;                   // external reset hold to count
   localparam int ANALOG_SETTLE_US = 10;                  // analog settle after standby
   // ----------------------------------------------------------------
   // carried groups
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       we;    // write strobe
      logic       re;    // read strobe
      logic [7:0] addr;  // register address
      logic [7:0] wdata; // write data
   } sfr_req_t;
   typedef enum logic [1:0] {
      PM_RUN, PM_IDLE, PM_DOWN, PM_WAKE
   } pm_state_t;
endpackage

/* tb/watchdog_power_chk.sv */
// checker: port-level assertions for the watchdog and power-mode block
`timescale 1ns/100ps
`default_nettype none
module watchdog_power_chk (
   input wire logic               clk,           // system clock
   input wire logic               sys_rst,       // sync reset
   input wire wdpm_pkg::sfr_req_t sfr_req,       // register request
   input wire logic [7:0]         sfr_rdata,     // read data
   input wire logic               ext_reset_pin, // reset pin
   input wire logic               irq_pending,   // enabled interrupt
   input wire logic               ext_irq_level, // level interrupt
   input wire logic               cpu_clk_en,    // cpu clock enable
   input wire logic               periph_clk_en, // peripheral clock enable
   input wire logic               osc_run,       // oscillator running
   input wire logic               analog_en,     // analog enable
   input wire logic               pin_hold,      // pins held
   input wire logic               chip_reset     // device reset
);
   logic [11:0] dark_q; // cycles with peripheral clock off
   logic [5:0]  rlen_q; // cycles with device reset high
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ------------------------------------------------
   // helper counters
   // ------------------------------------------------
   // length of the current dark stretch, saturating
   always_ff @(posedge clk) begin
      dark_q <= periph_clk_en ? 12'h000 : ((&dark_q) ? dark_q : dark_q + 12'h001);
   end
   // length of the current reset pulse, saturating
   always_ff @(posedge clk) begin
      rlen_q <= !chip_reset ? 6'h00 : (sys_rst ? 6'h01 : ((&rlen_q) ? rlen_q : rlen_q + 6'h01));
   end
   // ------------------------------------------------
   // assertions
   // ------------------------------------------------
   a_standby_enter: assert property (sfr_req.we && sfr_req.addr == wdpm_pkg::STANDBY_CONTROL_ADDR
      && sfr_req.wdata[0] && cpu_clk_en && !chip_reset |-> ##[1:2] !analog_en)
      else $error("standby write did not drop analog enable");
   a_standby_runs: assert property ($fell(analog_en) |-> cpu_clk_en && periph_clk_en && osc_run)
      else $error("standby stopped a clock");
   a_idle_wake: assert property (irq_pending && !cpu_clk_en && periph_clk_en && osc_run
      && !chip_reset |-> ##[1:4] cpu_clk_en)
      else $error("interrupt did not restart cpu clock");
   a_halt_holds: assert property (!cpu_clk_en |-> pin_hold)
      else $error("pins not held while cpu halted");
   a_down_stops: assert property (!osc_run |-> !cpu_clk_en && !periph_clk_en && pin_hold)
      else $error("activity while oscillator stopped");
   a_wake_delay: assert property (periph_clk_en && dark_q != 12'h000 && !chip_reset
      |-> dark_q >= 12'h800)
      else $error("clock restarted before settle count");
   a_reset_width: assert property (!chip_reset && rlen_q != 6'h00 |-> rlen_q >= 6'h18)
      else $error("device reset pulse too short");
   a_reset_clears: assert property ($fell(chip_reset) |-> cpu_clk_en && osc_run
      && analog_en && !pin_hold)
      else $error("reset left a power mode active");
endmodule
bind watchdog_power watchdog_power_chk u_chk (.clk(clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
   .sfr_rdata(sfr_rdata), .ext_reset_pin(ext_reset_pin), .irq_pending(irq_pending),
   .ext_irq_level(ext_irq_level), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
   .osc_run(osc_run), .analog_en(analog_en), .pin_hold(pin_hold), .chip_reset(chip_reset));
`default_nettype wire

/* tb/watchdog_power_tb.sv */
// testbench: register, idle, power-down, reset and watchdog scenarios
`timescale 1ns/100ps
`default_nettype none
module watchdog_power_tb;
   localparam int         LIMIT = 230000;                         // run ceiling in cycles
   localparam int         TICK  = wdpm_pkg::TICK_CYCLES;          // watchdog tick
   localparam logic [7:0] PWR_A = wdpm_pkg::POWER_CONTROL_ADDR;   // power control
   localparam logic [7:0] STB_A = wdpm_pkg::STANDBY_CONTROL_ADDR; // standby control
   localparam logic [7:0] BWD_A = wdpm_pkg::BUSY_WATCHDOG_ADDR;   // watchdog control
   localparam logic [7:0] WDR_A = wdpm_pkg::WATCHDOG_RELOAD_ADDR; // reload value
   logic               clk = 1'b0, sys_rst = 1'b1;                // clock and reset
   logic               rst_pin = 1'b0, irq = 1'b0, lvl = 1'b0;    // pins
   wdpm_pkg::sfr_req_t sfr_req = '0;                              // register request
   logic [7:0]         rdata;                                     // read data
   logic               cpu, per, osc, ana, hold, crst;            // mode outputs
   int                 bad_count = 0, compares = 0, cyc = 0, n;   // counters
   // ------------------------------------------------
   // clock, timeout and design
   // ------------------------------------------------
   always #5 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         bad_count++;
         stop_test();
      end
   end
   watchdog_power DUT (.clk(clk), .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rdata(rdata),
      .ext_reset_pin(rst_pin), .irq_pending(irq), .ext_irq_level(lvl), .cpu_clk_en(cpu),
      .periph_clk_en(per), .osc_run(osc), .analog_en(ana), .pin_hold(hold), .chip_reset(crst));
   // ------------------------------------------------
   // shared tasks
   // ------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      sfr_req.we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      sfr_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      sfr_req.re <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic hold_cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // wait for the device reset to end, bounded
   task automatic wait_rst;
      n = 0;
      while (crst !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      hold_cyc(2);
      chk({7'h00, crst}, 8'h00);
   endtask
   task automatic stop_test;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_regs;
      rd(STB_A, 8'h00);
      rd(WDR_A, wdpm_pkg::WATCHDOG_RELOAD_RST);
      rd(BWD_A, 8'h00);
      wr(8'h80, 8'hFF);
      rd(8'h80, 8'h00);
      wr(STB_A, 8'h01);
      hold_cyc(3);
      chk({7'h00, ana}, 8'h00);
      chk({6'h00, cpu, osc}, 8'h03);
      wr(STB_A, 8'h00);
      hold_cyc(3);
      chk({7'h00, ana}, 8'h01);
      hold_cyc(wdpm_pkg::ANALOG_SETTLE_US * (wdpm_pkg::CLK_FREQ_HZ / 1000000));
      $display("test regs done");
   endtask
   task automatic t_reload;
      wr(WDR_A, 8'h55);
      rd(WDR_A, 8'h00);
      wr(PWR_A, 8'h10);
      rd(PWR_A, 8'h10);
      wr(WDR_A, 8'hF0);
      rd(WDR_A, 8'hF0);
      rd(PWR_A, 8'h00);
      $display("test reload done");
   endtask
   task automatic t_idle;
      wr(PWR_A, 8'h0D);
      hold_cyc(4);
      chk({5'h00, cpu, per, osc}, 8'h03);
      chk({7'h00, hold}, 8'h01);
      @(posedge clk) irq <= 1'b1;
      @(posedge clk) irq <= 1'b0;
      hold_cyc(4);
      chk({7'h00, cpu}, 8'h01);
      rd(PWR_A, 8'h0C);
      wr(PWR_A, 8'h00);
      $display("test idle done");
   endtask
   task automatic t_down;
      wr(BWD_A, 8'h02);
      wr(PWR_A, 8'h02);
      hold_cyc(4);
      chk({6'h00, osc, cpu}, 8'h03);
      rd(PWR_A, 8'h00);
      wr(BWD_A, 8'h00);
      wr(PWR_A, 8'h02);
      hold_cyc(4);
      chk({5'h00, osc, cpu, per}, 8'h00);
      chk({7'h00, hold}, 8'h01);
      @(posedge clk) lvl <= 1'b1;
      n = 0;
      while (cpu !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      lvl <= 1'b0;
      chk({7'h00, n >= 2048 && n < 2064}, 8'h01);
      rd(PWR_A, 8'h00);
      $display("test power-down done");
   endtask
   task automatic t_pin;
      wr(STB_A, 8'h01);
      wr(PWR_A, 8'h01);
      hold_cyc(4);
      @(posedge clk) rst_pin <= 1'b1;
      hold_cyc(30);
      chk({7'h00, crst}, 8'h01);
      @(posedge clk) rst_pin <= 1'b0;
      wait_rst();
      chk({6'h00, cpu, ana}, 8'h03);
      rd(PWR_A, 8'h00);
      rd(STB_A, 8'h00);
      $display("test reset pin done");
   endtask
   task automatic t_wdog;
      wr(BWD_A, 8'h02);
      wr(PWR_A, 8'h10);
      wr(WDR_A, 8'hFF);
      wr(PWR_A, 8'h01);
      n = 0;
      while (crst !== 1'b1 && n < TICK + 100) begin
         @(posedge clk);
         n++;
      end
      chk({7'h00, n >= TICK - 30 && n <= TICK + 30}, 8'h01);
      wait_rst();
      rd(BWD_A, 8'h00);
      rd(WDR_A, wdpm_pkg::WATCHDOG_RELOAD_RST);
      $display("test watchdog done");
   endtask
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      wait_rst();
      t_regs();
      t_reload();
      t_idle();
      t_down();
      t_pin();
      t_wdog();
      stop_test();
   end
endmodule
`default_nettype wire
